// ---- bench/chgseq_host_model.sv ----
// Serial bus host model issuing word writes and word reads.
// Assumes the bench resolves the data wire with a pull-up.
`timescale 1ns/1ps
`default_nettype none
`include "chgseq_params.svh"

module chgseq_host_model (
  // Host pins
  output logic      scl,
  output logic      sda_pull,
  // Resolved data wire
  input  wire logic sda
);
  // Idle bus; the clock stands still high between frames.
  initial begin
    scl = 1'b1;
    sda_pull = 1'b0;
  end

  // Start or restart: data falls while the clock is high.
  task automatic bus_start();
    sda_pull = 1'b0;
    #8 scl = 1'b1;
    #8 sda_pull = 1'b1;
    #8 scl = 1'b0;
  endtask

  task automatic bus_stop();
    #8 sda_pull = 1'b1;
    #8 scl = 1'b1;
    #8 sda_pull = 1'b0;
    #8;
  endtask

  // One 32 ns clock; data moves only while the clock is low.
  task automatic bus_bit(input logic b, output logic r);
    #8 sda_pull = !b;
    #8 scl = 1'b1;
    #8 r = sda;
    #8 scl = 1'b0;
  endtask

  // Byte out, MSB first; a low ninth bit is the acknowledge.
  task automatic tx_byte(input logic [7:0] d, inout logic ok);
    logic r;
    for (int i = 7; i >= 0; i--)
      bus_bit(d[i], r);
    bus_bit(1'b1, r);
    ok = ok & !r;
  endtask

  // Byte in; the last byte read is not acknowledged.
  task automatic rx_byte(input logic last, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bus_bit(1'b1, r);
      d[i] = r;
    end
    bus_bit(last, r);
  endtask

  // Word write: address with write bit, command, low, high.
  task automatic write_word(input logic [6:0] a, input logic [7:0] c, input logic [15:0] w,
                            output logic ok);
    ok = 1'b1;
    bus_start();
    tx_byte({a, 1'b0}, ok);
    tx_byte(c, ok);
    tx_byte(w[7:0], ok);
    tx_byte(w[15:8], ok);
    bus_stop();
  endtask

  // Word read: command, restart, address with read bit, low then high.
  task automatic read_word(input logic [7:0] c, output logic [15:0] w, output logic ok);
    ok = 1'b1;
    bus_start();
    tx_byte({`CHGSEQ_SLAVE_ADDR, 1'b0}, ok);
    tx_byte(c, ok);
    bus_start();
    tx_byte({`CHGSEQ_SLAVE_ADDR, 1'b1}, ok);
    rx_byte(1'b0, w[7:0]);
    rx_byte(1'b1, w[15:8]);
    bus_stop();
  endtask
endmodule
`default_nettype wire

// ---- bench/chgseq_top_chk.sv ----
// Checker on the charger core ports, bound into every chgseq_top.
// Assumes checks sample on clk_sys and rst_n disables them.
`timescale 1ns/1ps
`default_nettype none
`include "chgseq_params.svh"

module chgseq_top_chk
  import chgseq_pkg::*;
#(
  parameter int OFF_W = 16
) (
  // Clock and reset
  input wire logic                      clk_sys,
  input wire logic                      rst_n,
  // Serial pins
  input wire logic                      smb_scl,
  input wire logic                      smb_sda_i,
  input wire logic                      smb_sda_o,
  input wire logic                      smb_sda_oe,
  // Flags and off-time
  input wire chgseq_cmp_t               cmp_flags,
  input wire logic [OFF_W-1:0]          offtime_cycles,
  // Settings and gate drives
  input wire logic [`CHGSEQ_CUR_W-1:0]  current_setting,
  input wire logic [`CHGSEQ_VOLT_W-1:0] voltage_setting,
  input wire logic                      high_switch_drive,
  input wire logic                      low_switch_drive
);
  logic [7:0] gap_q;
  logic [7:0] gap_d;

  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  // Low time of the high drive, saturating so it never wraps.
  always_comb begin
    gap_d = gap_q;
    if (high_switch_drive)
      gap_d = 8'h00;
    else if (gap_q != 8'hff)
      gap_d = gap_q + 8'h01;
  end

  // Starts saturated so the first cycle is not held to the floor.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n)
      gap_q <= 8'hff;
    else
      gap_q <= gap_d;
  end

  a_no_overlap: assert property (!(high_switch_drive && low_switch_drive))
    else $error("drives overlap");
  a_dead_gap: assert property ($fell(high_switch_drive) |-> !low_switch_drive [*8])
    else $error("dead time broken");
  a_start_low_off: assert property ($rose(high_switch_drive) |-> !low_switch_drive)
    else $error("low on at start");
  a_peak_ends_on:
    assert property (high_switch_drive && $rose(cmp_flags.peak_compare_flag)
      |-> ##[1:4] !high_switch_drive) else $error("peak kept on-time");
  a_limit_ends_on:
    assert property (high_switch_drive && cmp_flags.overcurrent_flag
      |-> ##[1:4] !high_switch_drive) else $error("limit kept on-time");
  a_limit_holds:
    assert property (cmp_flags.overcurrent_flag [*4] |-> !$rose(high_switch_drive))
      else $error("start in overcurrent");
  a_min_level_idle:
    assert property (!cmp_flags.min_level_flag [*5] |-> !high_switch_drive && !low_switch_drive)
      else $error("drives on at low level");
  a_zero_cross_off:
    assert property ($rose(cmp_flags.zero_cross_flag) && low_switch_drive
      |-> ##[1:4] !low_switch_drive) else $error("zero cross kept low on");
  // Ten dead cycles plus at least 60 off cycles.
  a_off_floor: assert property ($rose(high_switch_drive) |-> gap_q >= 8'h46)
    else $error("off-time under floor");
  a_sda_scl_low: assert property ($changed(smb_sda_oe) |-> !smb_scl)
    else $error("data moved in clock high");

  c_peak_exit: cover property (high_switch_drive && $rose(cmp_flags.peak_compare_flag));
  c_ack: cover property ($rose(smb_sda_oe) && !smb_sda_o);
  c_off_time: cover property ($rose(low_switch_drive));
endmodule

bind chgseq_top chgseq_top_chk #(.OFF_W(OFF_W)) i_chgseq_top_chk (
  .clk_sys, .rst_n, .smb_scl, .smb_sda_i, .smb_sda_o, .smb_sda_oe, .cmp_flags,
  .offtime_cycles, .current_setting, .voltage_setting, .high_switch_drive, .low_switch_drive
);
`default_nettype wire

// ---- bench/chgseq_top_tb_top.sv ----
// Self-checking bench: register rows, then sequencer cases.
// Assumes the host model owns the serial pins.
`timescale 1ns/1ps
`default_nettype none
`include "chgseq_params.svh"

module chgseq_top_tb_top
  import chgseq_pkg::*;
;
  localparam logic [15:0] MAKER_ID = 16'h5a3c; // Arbitrary value.
  localparam logic [15:0] PART_ID  = 16'h0c21; // Arbitrary value.

  typedef struct packed {
    logic [7:0]  cmd;
    logic [15:0] wr;
    logic [5:0]  cur;
    logic [10:0] volt;
    logic [15:0] rd;
  } chgseq_row_t;

  logic        clk_sys;
  logic        rst_n;
  chgseq_cmp_t cmp_flags;
  logic [15:0] offtime_cycles;
  logic        scl;
  logic        host_pull;
  logic        sda_wire;
  logic        sda_o;
  logic        sda_oe;
  logic [5:0]  cur_set;
  logic [10:0] volt_set;
  logic        hi_drv;
  logic        lo_drv;
  int          mismatches;
  int          comparisons;
  logic        ok;
  logic [15:0] rd;
  int          dead;
  int          off;
  chgseq_row_t rows [6] = '{
    '{`CHGSEQ_CMD_CURRENT, 16'hffff, 6'h3f, 11'h000, 16'h0000},
    '{`CHGSEQ_CMD_VOLTAGE, 16'hffff, 6'h3f, 11'h7ff, 16'h0000},
    '{`CHGSEQ_CMD_CURRENT, 16'h0420, 6'h21, 11'h7ff, 16'h0000},
    '{`CHGSEQ_CMD_VOLTAGE, 16'h8010, 6'h21, 11'h001, 16'h0000},
    '{`CHGSEQ_CMD_MAKER, 16'h1234, 6'h21, 11'h001, MAKER_ID},
    '{`CHGSEQ_CMD_PART, 16'h1234, 6'h21, 11'h001, PART_ID}};
  logic [15:0] offs [3] = '{16'h0064, 16'h0014, 16'h0064};
  logic        drops [3] = '{1'b0, 1'b0, 1'b1};
  logic [15:0] exp_off [3] = '{16'h0064, 16'h003c, 16'h003c};

  // Open-drain data wire with a pull-up.
  assign sda_wire = (host_pull || sda_oe) ? 1'b0 : 1'b1;

  chgseq_top #(.OFF_W(16), .MAKER_ID(MAKER_ID), .PART_ID(PART_ID)) i_chgseq_top (
    .clk_sys(clk_sys), .rst_n(rst_n), .smb_scl(scl), .smb_sda_i(sda_wire),
    .smb_sda_o(sda_o), .smb_sda_oe(sda_oe), .cmp_flags(cmp_flags),
    .offtime_cycles(offtime_cycles), .current_setting(cur_set), .voltage_setting(volt_set),
    .high_switch_drive(hi_drv), .low_switch_drive(lo_drv));
  chgseq_host_model i_chgseq_host_model (.scl(scl), .sda_pull(host_pull), .sda(sda_wire));

  // 200 MHz system clock.
  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic summarize();
    if (mismatches == 0 && comparisons > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // Waits for a drive level; running out of cycles ends the run.
  task automatic wait_drv(input logic low_side, input logic val, input int lim);
    int n = 0;
    while (((low_side ? lo_drv : hi_drv) !== val) && n < lim) begin
      @(posedge clk_sys);
      #1;
      n++;
    end
    if (n >= lim) begin
      mismatches++;
      summarize();
    end
  endtask

  // Counts dead cycles, then low-drive cycles, dropping the peak flag.
  task automatic measure(output int d, output int o);
    d = 0;
    o = 0;
    while (lo_drv === 1'b0 && d < 400) begin
      @(posedge clk_sys);
      cmp_flags.peak_compare_flag <= 1'b0;
      #1;
      d++;
    end
    while (lo_drv === 1'b1 && hi_drv === 1'b0 && o < 400) begin
      @(posedge clk_sys);
      #1;
      o++;
    end
  endtask

  // The high drive stays off for n cycles.
  task automatic stay_off(input int n);
    logic seen = 1'b0;
    repeat (n) begin
      @(posedge clk_sys);
      #1;
      seen = seen | (hi_drv !== 1'b0);
    end
    check("restart held", 16'(seen), 16'h0000);
  endtask

  initial begin
    rst_n = 1'b0;
    cmp_flags = '0;
    offtime_cycles = 16'h0064;
    mismatches = 0;
    comparisons = 0;
    repeat (5) @(posedge clk_sys);
    rst_n <= 1'b1;
    repeat (5) @(posedge clk_sys);
    #1;
    check("current reset", 16'(cur_set), 16'h0000);
    check("voltage reset", 16'(volt_set), 16'h0000);
    check("drives idle", {14'h0000, hi_drv, lo_drv}, 16'h0000);
    // Register rows: write, check settings, read back.
    foreach (rows[i]) begin
      i_chgseq_host_model.write_word(`CHGSEQ_SLAVE_ADDR, rows[i].cmd, rows[i].wr, ok);
      check("write ack", 16'(ok), 16'h0001);
      check("current", 16'(cur_set), 16'(rows[i].cur));
      check("voltage", 16'(volt_set), 16'(rows[i].volt));
      i_chgseq_host_model.read_word(rows[i].cmd, rd, ok);
      check("read ack", 16'(ok), 16'h0001);
      check("read word", rd, rows[i].rd);
    end
    // A foreign address gets no acknowledge.
    i_chgseq_host_model.write_word(7'h0a, `CHGSEQ_CMD_CURRENT, 16'h0000, ok);
    check("foreign ack", 16'(ok), 16'h0000);
    check("current kept", 16'(cur_set), 16'h0021);
    @(posedge clk_sys);
    cmp_flags.min_level_flag <= 1'b1;
    #1;
    // Off-time cases: long count, short count floored, dropout.
    foreach (offs[i]) begin
      @(posedge clk_sys);
      offtime_cycles <= offs[i];
      cmp_flags.dropout <= drops[i];
      #1;
      wait_drv(1'b0, 1'b1, 400);
      check("low at start", 16'(lo_drv), 16'h0000);
      @(posedge clk_sys);
      cmp_flags.peak_compare_flag <= 1'b1;
      #1;
      wait_drv(1'b0, 1'b0, 8);
      measure(dead, off);
      check("dead time", 16'(dead), 16'h000a);
      check("off count", 16'(off), exp_off[i]);
    end
    // Overcurrent cuts the on-time and holds off the next.
    @(posedge clk_sys);
    cmp_flags.overcurrent_flag <= 1'b1;
    #1;
    wait_drv(1'b0, 1'b0, 8);
    stay_off(250);
    @(posedge clk_sys);
    cmp_flags.overcurrent_flag <= 1'b0;
    #1;
    wait_drv(1'b0, 1'b1, 20);
    // Zero cross in the off-time drops the low drive.
    @(posedge clk_sys);
    cmp_flags.peak_compare_flag <= 1'b1;
    #1;
    wait_drv(1'b0, 1'b0, 8);
    wait_drv(1'b1, 1'b1, 20);
    @(posedge clk_sys);
    cmp_flags.peak_compare_flag <= 1'b0;
    cmp_flags.zero_cross_flag <= 1'b1;
    #1;
    wait_drv(1'b1, 1'b0, 6);
    // Low min level idles both drives.
    @(posedge clk_sys);
    cmp_flags.zero_cross_flag <= 1'b0;
    cmp_flags.min_level_flag <= 1'b0;
    #1;
    stay_off(250);
    check("low held", 16'(lo_drv), 16'h0000);
    @(posedge clk_sys);
    cmp_flags.min_level_flag <= 1'b1;
    #1;
    wait_drv(1'b0, 1'b1, 20);
    // Mid-run reset clears settings and drives at once.
    @(posedge clk_sys);
    rst_n <= 1'b0;
    #1;
    check("reset clears", {sda_oe, sda_o, hi_drv, lo_drv, 1'h0, volt_set}, 16'h0000);
    check("current cleared", 16'(cur_set), 16'h0000);
    repeat (5) @(posedge clk_sys);
    rst_n <= 1'b1;
    repeat (5) @(posedge clk_sys);
    summarize();
  end
endmodule
`default_nettype wire

// ---- core/chgseq_switch.sv ----
// Switching-cycle sequencer driving the high-side and low-side gates.
// Assumes comparator flags are asynchronous and the off-time count comes
// from logic on clk_sys.
`timescale 1ns/1ps
`default_nettype none
`include "chgseq_params.svh"

module chgseq_switch
  import chgseq_pkg::*;
#(
  parameter int OFF_W = 16
) (
  // Clock and reset
  input  wire logic             clk_sys,
  input  wire logic             rst_n,
  // Comparator flags, asynchronous
  input  wire chgseq_cmp_t      cmp_flags,
  // Computed off-time in clk_sys cycles
  input  wire logic [OFF_W-1:0] offtime_cycles,
  // Gate drives
  output logic                  high_switch_drive,
  output logic                  low_switch_drive
);

  localparam logic [OFF_W-1:0] DEAD_CYC    = OFF_W'(`CHGSEQ_DEAD_CYC);
  localparam logic [OFF_W-1:0] MIN_OFF_CYC = OFF_W'(`CHGSEQ_MIN_OFF_CYC);
  localparam int               NFLAG       = $bits(chgseq_cmp_t);

  logic [NFLAG-1:0] meta_q;
  chgseq_cmp_t      flg_s;
  chgseq_sw_state_t state_q, state_d;
  logic [OFF_W-1:0] cnt_q, cnt_d, off_q, off_d;
  logic             pk_prev_q, ls_en_q, ls_en_d, hs_q, hs_d, ls_q, ls_d;
  logic             pk_rise;

  // Two-flop synchroniser for every comparator flag.
  genvar gi;
  generate
    for (gi = 0; gi < NFLAG; gi++) begin : g_sync
      always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
          meta_q[gi] <= 1'b0;
          flg_s[gi]  <= 1'b0;
        end else begin
          meta_q[gi] <= cmp_flags[gi];
          flg_s[gi]  <= meta_q[gi];
        end
      end
    end
  endgenerate

  assign pk_rise = flg_s.peak_compare_flag & ~pk_prev_q;

  // Next phase; the outputs are registered from the next phase so the
  // gates change in the same edge as the phase itself.
  always_comb begin
    state_d = state_q;
    cnt_d   = cnt_q;
    off_d   = off_q;
    ls_en_d = ls_en_q;
    case (state_q)
      SW_WAIT: begin
        if (flg_s.min_level_flag && !flg_s.overcurrent_flag) begin
          state_d = SW_ON;
        end
      end
      SW_ON: begin
        // Overcurrent ends the on-time at once; so does a low control level.
        if (pk_rise || flg_s.overcurrent_flag || !flg_s.min_level_flag) begin
          state_d = SW_DEAD;
          cnt_d   = DEAD_CYC;
          ls_en_d = 1'b1;
          if (flg_s.dropout || offtime_cycles < MIN_OFF_CYC) begin
            off_d = MIN_OFF_CYC;
          end else begin
            off_d = offtime_cycles;
          end
        end
      end
      SW_DEAD: begin
        if (cnt_q <= 1) begin
          state_d = SW_OFF;
          cnt_d   = off_q;
        end else begin
          cnt_d = cnt_q - 1'b1;
        end
      end
      SW_OFF: begin
        if (cnt_q <= 1) begin
          if (flg_s.min_level_flag && !flg_s.overcurrent_flag) begin
            state_d = SW_ON;
          end else begin
            state_d = SW_WAIT;
          end
        end else begin
          cnt_d = cnt_q - 1'b1;
        end
      end
      default: state_d = SW_WAIT;
    endcase
    // Zero crossing ends low-side conduction for the rest of the cycle.
    if (flg_s.zero_cross_flag && (state_q == SW_OFF || state_q == SW_WAIT)) begin
      ls_en_d = 1'b0;
    end
    hs_d = (state_d == SW_ON);
    ls_d = (state_d == SW_OFF || state_d == SW_WAIT) && ls_en_d
           && flg_s.min_level_flag;
  end

  // Sequencer registers.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state_q   <= SW_WAIT;
      cnt_q     <= '0;
      off_q     <= '0;
      pk_prev_q <= 1'b0;
      ls_en_q   <= 1'b0;
      hs_q      <= 1'b0;
      ls_q      <= 1'b0;
    end else begin
      state_q   <= state_d;
      cnt_q     <= cnt_d;
      off_q     <= off_d;
      pk_prev_q <= flg_s.peak_compare_flag;
      ls_en_q   <= ls_en_d;
      hs_q      <= hs_d;
      ls_q      <= ls_d;
    end
  end

  assign high_switch_drive = hs_q;
  assign low_switch_drive  = ls_q;

endmodule
`default_nettype wire

// ---- core/chgseq_top.sv ----
// Charger digital core: two-wire serial slave for setpoints and identity,
// plus the switching-cycle sequencer.
// Assumes the serial clock pin is a clock of its own, an external pull-up on
// the data line, and asynchronous comparator flags.
//
// Function
// - Word read: address, command, restart, low-then-high.
// - Ack pulls data low; host naks last read.
// - Command 0x14 current setpoint, six bits, reset zero.
// - Command 0x15 voltage setpoint, eleven bits, reset zero.
// - Commands 0xfe, 0xff return fixed identity words.
// - Cycle start: high drive on, low off.
// - Peak compare rise ends on-time, starts off-time.
// - New cycle needs min level high, overcurrent low.
// - Overcurrent ends the on-time immediately.
// - Dropout forces the fixed minimum off-time.
// - Discontinuous mode waits for min level flag.
// - Min level low holds both drives low.
// - Zero cross turns low drive off.
// - Dead time before low drive turns on.
`timescale 1ns/1ps
`default_nettype none
`include "chgseq_params.svh"

module chgseq_top
  import chgseq_pkg::*;
#(
  parameter int          OFF_W   = 16,
  parameter logic [15:0] MAKER_ID = 16'h00a5, // Arbitrary value.
  parameter logic [15:0] PART_ID  = 16'h0031  // Arbitrary value.
) (
  // System clock and reset
  input  wire logic                      clk_sys,
  input  wire logic                      rst_n,
  // Serial bus pins; the clock pin clocks the link logic
  input  wire logic                      smb_scl,
  input  wire logic                      smb_sda_i,
  output logic                           smb_sda_o,
  output logic                           smb_sda_oe,
  // Comparator flags
  input  wire chgseq_cmp_t               cmp_flags,
  // Off-time from the off-time calculator
  input  wire logic [OFF_W-1:0]          offtime_cycles,
  // Setpoints toward the converters
  output logic [`CHGSEQ_CUR_W-1:0]       current_setting,
  output logic [`CHGSEQ_VOLT_W-1:0]      voltage_setting,
  // Gate drives
  output logic                           high_switch_drive,
  output logic                           low_switch_drive
);

  // System-domain state.
  logic                      scl_m_q, scl_s_q, sda_m_q, sda_s_q, sda_p_q;
  logic                      scl_m_d, scl_s_d, sda_m_d, sda_s_d, sda_p_d;
  logic                      frame_clr_q, frame_clr_d;
  logic                      tgl_m_q, tgl_s_q, tgl_p_q;
  logic                      tgl_m_d, tgl_s_d, tgl_p_d;
  logic [`CHGSEQ_CUR_W-1:0]  cur_q, cur_d;
  logic [`CHGSEQ_VOLT_W-1:0] volt_q, volt_d;
  logic                      start_seen, stop_seen, link_rst_n;

  // Link-domain frame state, cleared at every start and stop.
  chgseq_link_state_t        state_q, state_d;
  logic [3:0]                cnt_q, cnt_d;
  logic [6:0]                shreg_q, shreg_d;
  logic                      ack_q, ack_d;

  // Link-domain command and write holding, kept across a repeated start.
  logic [7:0]                cmd_q, cmd_d, lo_q, lo_d;
  chgseq_wr_t                wr_q, wr_d;
  logic                      wr_tgl_q, wr_tgl_d;

  // Link-domain data line driver, updated on the falling clock edge.
  logic                      oe_q, oe_d;

  logic [7:0]                rx_byte;
  logic                      byte_done, wr_commit, rd_phase, rd_bit;
  logic [15:0]               rd_word;
  logic [7:0]                rd_byte;

  // Start and stop are seen from the oversampled pins; the link clock cannot
  // see them because it does not toggle across a stop-then-start.
  assign start_seen = scl_s_q & sda_p_q & ~sda_s_q;
  assign stop_seen  = scl_s_q & ~sda_p_q & sda_s_q;

  // System-domain next values: pin synchronisers, frame clear, write capture.
  always_comb begin
    scl_m_d     = smb_scl;
    scl_s_d     = scl_m_q;
    sda_m_d     = smb_sda_i;
    sda_s_d     = sda_m_q;
    sda_p_d     = sda_s_q;
    tgl_m_d     = wr_tgl_q;
    tgl_s_d     = tgl_m_q;
    tgl_p_d     = tgl_s_q;
    cur_d       = cur_q;
    volt_d      = volt_q;
    frame_clr_d = frame_clr_q;
    // The clear holds the link logic idle from a start or stop until the
    // clock falls, long before the first data edge of the next byte.
    if (start_seen || stop_seen) begin
      frame_clr_d = 1'b1;
    end else if (!scl_s_q) begin
      frame_clr_d = 1'b0;
    end
    // A toggle edge marks a completed write; the held word is stable by then.
    if (tgl_s_q != tgl_p_q) begin
      if (wr_q.cmd == `CHGSEQ_CMD_CURRENT) begin
        cur_d = wr_q.word[`CHGSEQ_CUR_LSB +: `CHGSEQ_CUR_W];
      end else if (wr_q.cmd == `CHGSEQ_CMD_VOLTAGE) begin
        volt_d = wr_q.word[`CHGSEQ_VOLT_LSB +: `CHGSEQ_VOLT_W];
      end
    end
  end

  // System-domain registers.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      scl_m_q     <= 1'b1;
      scl_s_q     <= 1'b1;
      sda_m_q     <= 1'b1;
      sda_s_q     <= 1'b1;
      sda_p_q     <= 1'b1;
      frame_clr_q <= 1'b1;
      tgl_m_q     <= 1'b0;
      tgl_s_q     <= 1'b0;
      tgl_p_q     <= 1'b0;
      cur_q       <= `CHGSEQ_CUR_W'(`CHGSEQ_SETPOINT_RST);
      volt_q      <= `CHGSEQ_VOLT_W'(`CHGSEQ_SETPOINT_RST);
    end else begin
      scl_m_q     <= scl_m_d;
      scl_s_q     <= scl_s_d;
      sda_m_q     <= sda_m_d;
      sda_s_q     <= sda_s_d;
      sda_p_q     <= sda_p_d;
      frame_clr_q <= frame_clr_d;
      tgl_m_q     <= tgl_m_d;
      tgl_s_q     <= tgl_s_d;
      tgl_p_q     <= tgl_p_d;
      cur_q       <= cur_d;
      volt_q      <= volt_d;
    end
  end

  // The frame clear comes from a flop, so this reset is glitch free; it is
  // released while the link clock is low, away from its rising edge.
  assign link_rst_n = rst_n & ~frame_clr_q;

  assign byte_done = (cnt_q == 4'h7);
  assign rx_byte   = {shreg_q, smb_sda_i};
  assign wr_commit = byte_done && (state_q == LK_WHI)
                     && (cmd_q == `CHGSEQ_CMD_CURRENT || cmd_q == `CHGSEQ_CMD_VOLTAGE);

  // Frame sequencing: data sampled on the rising clock edge.
  always_comb begin
    state_d = state_q;
    cnt_d   = cnt_q;
    shreg_d = shreg_q;
    ack_d   = ack_q;
    if (cnt_q != `CHGSEQ_ACK_SLOT) begin
      shreg_d = rx_byte[6:0];
      cnt_d   = cnt_q + 4'h1;
    end else begin
      cnt_d = 4'h0;
      ack_d = 1'b0;
    end
    if (byte_done) begin
      case (state_q)
        LK_ADDR: begin
          if (rx_byte[7:1] == `CHGSEQ_SLAVE_ADDR) begin
            ack_d   = 1'b1;
            // Direction bit: low writes, high reads.
            state_d = rx_byte[0] ? LK_RLO : LK_CMD;
          end else begin
            state_d = LK_IGNORE;
          end
        end
        LK_CMD: begin
          ack_d   = 1'b1;
          state_d = LK_WLO;
        end
        LK_WLO: begin
          ack_d   = 1'b1;
          state_d = LK_WHI;
        end
        LK_WHI: begin
          ack_d   = 1'b1;
          state_d = LK_IGNORE;
        end
        default: ;
      endcase
    end
    // The host answers read bytes; ack_q marks the address slot.
    if (cnt_q == `CHGSEQ_ACK_SLOT && !ack_q) begin
      case (state_q)
        LK_RLO:  state_d = smb_sda_i ? LK_IGNORE : LK_RHI;
        LK_RHI:  state_d = LK_IGNORE;
        default: ;
      endcase
    end
  end

  // Frame registers on the link clock.
  always_ff @(posedge smb_scl or negedge link_rst_n) begin
    if (!link_rst_n) begin
      state_q <= LK_ADDR;
      cnt_q   <= 4'h0;
      shreg_q <= 7'h00;
      ack_q   <= 1'b0;
    end else begin
      state_q <= state_d;
      cnt_q   <= cnt_d;
      shreg_q <= shreg_d;
      ack_q   <= ack_d;
    end
  end

  // Command and write holding; survives the repeated start of a word read.
  always_comb begin
    cmd_d    = cmd_q;
    lo_d     = lo_q;
    wr_d     = wr_q;
    wr_tgl_d = wr_tgl_q;
    if (byte_done && state_q == LK_CMD) begin
      cmd_d = rx_byte;
    end
    if (byte_done && state_q == LK_WLO) begin
      lo_d = rx_byte;
    end
    // Identity commands accept the bytes but store nothing.
    if (wr_commit) begin
      wr_d.cmd  = cmd_q;
      wr_d.word = {rx_byte, lo_q};
      wr_tgl_d  = ~wr_tgl_q;
    end
  end

  // Holding registers on the link clock, reset only by rst_n.
  always_ff @(posedge smb_scl or negedge rst_n) begin
    if (!rst_n) begin
      cmd_q    <= 8'h00;
      lo_q     <= 8'h00;
      wr_q     <= '0;
      wr_tgl_q <= 1'b0;
    end else begin
      cmd_q    <= cmd_d;
      lo_q     <= lo_d;
      wr_q     <= wr_d;
      wr_tgl_q <= wr_tgl_d;
    end
  end

  // Read data: identity words are fixed, write-only setpoints read as zero.
  always_comb begin
    case (cmd_q)
      `CHGSEQ_CMD_MAKER: rd_word = MAKER_ID;
      `CHGSEQ_CMD_PART:  rd_word = PART_ID;
      default:           rd_word = 16'h0000;
    endcase
  end

  // Low byte first, most significant bit first within a byte.
  assign rd_byte  = (state_q == LK_RHI) ? rd_word[15:8] : rd_word[7:0];
  assign rd_phase = (state_q == LK_RLO || state_q == LK_RHI);
  assign rd_bit   = rd_byte[3'h7 - cnt_q[2:0]];

  // Data line drive, changed only while the clock is low.
  always_comb begin
    if (cnt_q == `CHGSEQ_ACK_SLOT) begin
      oe_d = ack_q;
    end else begin
      oe_d = rd_phase & ~rd_bit;
    end
  end

  // Driver register on the falling link clock edge.
  always_ff @(negedge smb_scl or negedge link_rst_n) begin
    if (!link_rst_n) begin
      oe_q <= 1'b0;
    end else begin
      oe_q <= oe_d;
    end
  end

  // Open-drain data pin: the level driven is always low.
  assign smb_sda_o  = 1'b0;
  assign smb_sda_oe = oe_q;

  assign current_setting = cur_q;
  assign voltage_setting = volt_q;

  // Gate sequencer on the system clock.
  chgseq_switch #(
    .OFF_W (OFF_W)
  ) u_switch (
    .clk_sys           (clk_sys),
    .rst_n             (rst_n),
    .cmp_flags         (cmp_flags),
    .offtime_cycles    (offtime_cycles),
    .high_switch_drive (high_switch_drive),
    .low_switch_drive  (low_switch_drive)
  );

endmodule
`default_nettype wire

// ---- inc/chgseq_params.svh ----
// Constants of the charger command port and switch sequencer.
// Assumes a 200 MHz system clock; included by both design files.
`ifndef CHGSEQ_PARAMS_SVH
`define CHGSEQ_PARAMS_SVH

// Serial slave address and command codes.
`define CHGSEQ_SLAVE_ADDR     7'h09
`define CHGSEQ_CMD_CURRENT    8'h14
`define CHGSEQ_CMD_VOLTAGE    8'h15
`define CHGSEQ_CMD_MAKER      8'hfe
`define CHGSEQ_CMD_PART       8'hff

// Setpoint reset value and field layout inside the 16-bit word.
`define CHGSEQ_SETPOINT_RST   16'h0000
`define CHGSEQ_CUR_LSB        5
`define CHGSEQ_CUR_W          6
`define CHGSEQ_VOLT_LSB       4
`define CHGSEQ_VOLT_W         11

// Bit slot of the acknowledge within a nine-clock byte.
`define CHGSEQ_ACK_SLOT       4'h8

// Timing: clock period in ps and the printed times in ns.
`define CHGSEQ_CLK_PS         5000
`define CHGSEQ_DEAD_NS        50
`define CHGSEQ_MIN_OFF_NS     300
// Least times, rounded up to whole clock cycles.
`define CHGSEQ_DEAD_CYC    ((`CHGSEQ_DEAD_NS * 1000 + `CHGSEQ_CLK_PS - 1) / `CHGSEQ_CLK_PS)
`define CHGSEQ_MIN_OFF_CYC ((`CHGSEQ_MIN_OFF_NS * 1000 + `CHGSEQ_CLK_PS - 1) / `CHGSEQ_CLK_PS)

`endif

// ---- inc/chgseq_pkg.sv ----
// Types shared by the charger command port and the switch sequencer.
// Assumes no other package; constants live in chgseq_params.svh.
package chgseq_pkg;

  // Serial link byte phases.
  typedef enum logic [2:0] {
    LK_ADDR   = 3'b000,
    LK_CMD    = 3'b001,
    LK_WLO    = 3'b010,
    LK_WHI    = 3'b011,
    LK_RLO    = 3'b100,
    LK_RHI    = 3'b101,
    LK_IGNORE = 3'b110
  } chgseq_link_state_t;

  // Switching-cycle phases.
  typedef enum logic [1:0] {
    SW_WAIT = 2'b00,
    SW_ON   = 2'b01,
    SW_DEAD = 2'b10,
    SW_OFF  = 2'b11
  } chgseq_sw_state_t;

  // Comparator flags as they arrive from the analog side.
  typedef struct packed {
    logic dropout;
    logic zero_cross_flag;
    logic overcurrent_flag;
    logic min_level_flag;
    logic peak_compare_flag;
  } chgseq_cmp_t;

  // A completed word write, held for the crossing into the system clock.
  typedef struct packed {
    logic [7:0]  cmd;
    logic [15:0] word;
  } chgseq_wr_t;

endpackage
